// ==== logic/i2c_start_seq.sv ====
// I2C master start and repeated-start sequencer with an APB register slave.
// Assumes SDA/SCL are open-drain with external pull-ups, sampled asynchronously.
//
// Operation
// - Repeated start only begins from idle on request bit; first drive SCL low.
// - SCL seen low: load counter from reload low six bits, release SDA.
// - Count expiry with SDA high releases SCL.
// - SCL seen high: reload seven bits; SDA and SCL must stay high.
// - Then SDA low one period, request bit self-clears, SDA stays low.
// - Any start condition seen on the bus sets the start-seen status bit.
// - Interrupt flag for repeated start only after the final count expires.
// - Repeated-start request while another event runs is ignored.
// - Repeated start collision: SDA low at SCL rise, or SCL falls early.
// - Buffer write during repeated start sets write collision, keeps contents.
// - Low five request bits are write-blocked until repeated start completes.
// - Start with SDA or SCL already low aborts, flags collision, goes idle.
// - Before the second start count, SCL low while SDA high is a collision.
// - Start begins released; SDA high loads seven-bit reload and counts down.
// - SDA low in first start count resets counter and drives SDA early.
// - SDA high through first count: drive SDA low, reload, count again.
// - SCL low during second start count is no collision.
// - Second count expiry drives SCL low, completing start.
// - Simultaneous starts are not a collision; arbitration continues.
`timescale 1ns/100ps
`default_nettype none
module i2c_start_seq
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // I2C clock line
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Status outputs
  output logic serial_port_irq_flag,
  output logic bus_collision_irq_flag
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sda_meta, sda_s, sda_d;
  logic scl_meta, scl_s, scl_d;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
    end else begin
      sda_meta <= sda_in;
      sda_s <= sda_meta;
      scl_meta <= scl_in;
      scl_s <= scl_meta;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
    end else begin
      sda_d <= sda_s;
      scl_d <= scl_s;
    end
  end

  // Edge history reads only the second stage, never the metastable first
  // Start = SDA falls while SCL high
  logic start_det;
  assign start_det = sda_d && !sda_s && scl_s && scl_d;

  // ----------------------------------------
  // Registers and APB decode
  // ----------------------------------------
  logic [7:0] serial_control_two;
  logic [6:0] baud_reload_value;
  logic [7:0] transfer_buffer;
  logic serial_status_start;
  logic write_collision_flag;
  seq_state_t state;
  logic [6:0] baud_counter;
  logic drive_sda_low, drive_scl_low;

  logic wr_en, rd_en, restart_busy, seq_busy;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign restart_busy = (state == st_r_scl_low) || (state == st_r_sda_rel) ||
                        (state == st_r_scl_rise) || (state == st_r_hold) ||
                        (state == st_r_sda_low);
  assign seq_busy = (state != st_idle);

  logic ctrl_wr, buf_wr, flags_wr, addr_ok;
  assign ctrl_wr = wr_en && (paddr == ctrl_two_addr);
  assign buf_wr = wr_en && (paddr == buffer_addr);
  assign flags_wr = wr_en && (paddr == flags_addr);
  assign addr_ok = (paddr == ctrl_two_addr) || (paddr == status_addr) ||
                   (paddr == reload_addr) || (paddr == buffer_addr) ||
                   (paddr == flags_addr);

  // Zero-wait slave: pready high in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ctrl_two_addr: prdata <= {24'h000000, serial_control_two};
        status_addr: prdata <= {27'h0000000, seq_busy, serial_status_start, 3'h0};
        reload_addr: prdata <= {25'h0000000, baud_reload_value};
        buffer_addr: prdata <= {24'h000000, transfer_buffer};
        flags_addr: prdata <= {29'h00000000, bus_collision_irq_flag,
                               write_collision_flag, serial_port_irq_flag};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_reload_value <= reload_reset;
    end else if (wr_en && paddr == reload_addr) begin
      baud_reload_value <= pwdata[6:0];
    end
  end

  // Buffer write refused during a repeated start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      transfer_buffer <= buffer_reset;
    end else if (buf_wr && !restart_busy) begin
      transfer_buffer <= pwdata[7:0];
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic cnt_zero, seq_done, seq_done_r, abort_col, restart_col;
  assign cnt_zero = (baud_counter == 7'h00);

  // Request bits are taken only while the sequencer is idle
  logic req_start, req_restart;
  assign req_start = ctrl_wr && !seq_busy && pwdata[start_req_bit];
  assign req_restart = ctrl_wr && !seq_busy && pwdata[restart_req_bit] &&
                       !pwdata[start_req_bit];

  // ----------------------------------------
  // Baud counter
  // ----------------------------------------
  // One owner for the counter; its loads follow the sequencer's own
  // transitions, and a load always wins over the decrement.
  logic cnt_load;
  logic [6:0] next_count;

  always_comb begin
    cnt_load = 1'b0;
    next_count = baud_reload_value;
    case (state)
      st_s_check: cnt_load = sda_s && scl_s;
      st_s_count1: cnt_load = !(!scl_s && sda_s) && (!sda_s || cnt_zero);
      st_r_scl_low: begin
        cnt_load = !scl_s;
        next_count = {1'b0, baud_reload_value[5:0]};
      end
      st_r_scl_rise: cnt_load = scl_s && sda_s;
      st_r_hold: cnt_load = scl_s && sda_s && cnt_zero;
      default: cnt_load = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_counter <= 7'h00;
    end else if (cnt_load) begin
      baud_counter <= next_count;
    end else if (!cnt_zero) begin
      baud_counter <= baud_counter - count_one;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= st_idle;
      drive_sda_low <= 1'b0;
      drive_scl_low <= 1'b0;
      seq_done <= 1'b0;
      abort_col <= 1'b0;
      restart_col <= 1'b0;
    end else begin
      seq_done <= 1'b0;
      abort_col <= 1'b0;
      restart_col <= 1'b0;
      case (state)
        st_idle: begin
          if (req_start) begin
            drive_sda_low <= 1'b0;
            drive_scl_low <= 1'b0;
            state <= st_s_check;
          end else if (req_restart) begin
            drive_scl_low <= 1'b1;
            state <= st_r_scl_low;
          end
        end
        st_s_check: begin
          if (!sda_s || !scl_s) begin
            abort_col <= 1'b1;
            state <= st_idle;
          end else begin
            state <= st_s_count1;
          end
        end
        st_s_count1: begin
          if (!scl_s && sda_s) begin
            abort_col <= 1'b1;
            state <= st_idle;
          end else if (!sda_s || cnt_zero) begin
            drive_sda_low <= 1'b1;
            state <= st_s_count2;
          end
        end
        st_s_count2: begin
          // SCL low here is another master's start: not a collision
          if (cnt_zero) begin
            drive_scl_low <= 1'b1;
            seq_done <= 1'b1;
            state <= st_idle;
          end
        end
        st_r_scl_low: begin
          if (!scl_s) begin
            drive_sda_low <= 1'b0;
            state <= st_r_sda_rel;
          end
        end
        st_r_sda_rel: begin
          if (cnt_zero && sda_s) begin
            drive_scl_low <= 1'b0;
            state <= st_r_scl_rise;
          end
        end
        st_r_scl_rise: begin
          if (scl_s && !sda_s) begin
            restart_col <= 1'b1;
            state <= st_idle;
          end else if (scl_s) begin
            state <= st_r_hold;
          end
        end
        st_r_hold: begin
          if (!scl_s || !sda_s) begin
            restart_col <= 1'b1;
            state <= st_idle;
          end else if (cnt_zero) begin
            drive_sda_low <= 1'b1;
            state <= st_r_sda_low;
          end
        end
        st_r_sda_low: begin
          // No reload after this period: SDA simply stays held low so the
          // address byte can follow without a glitch on the line.
          if (cnt_zero) begin
            seq_done <= 1'b1;
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
      // Lines are freed the cycle after a collision is found
      if (abort_col || restart_col) begin
        drive_sda_low <= 1'b0;
        drive_scl_low <= 1'b0;
      end
    end
  end

  // Completion flag delayed so the interrupt follows the final count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_done_r <= 1'b0;
    end else begin
      seq_done_r <= seq_done;
    end
  end

  // ----------------------------------------
  // Control register and flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_two <= ctrl_two_reset;
    end else begin
      if (ctrl_wr) begin
        serial_control_two[7:low_req_bits] <= pwdata[7:low_req_bits];
        if (!seq_busy) begin
          serial_control_two[low_req_bits-1:0] <= pwdata[low_req_bits-1:0];
        end
      end
      if (state != st_idle && state != st_s_check && state != st_s_count1 &&
          state != st_s_count2) begin
        serial_control_two[start_req_bit] <= 1'b0;
      end
      if (seq_done || abort_col || restart_col) begin
        serial_control_two[restart_req_bit] <= 1'b0;
        serial_control_two[start_req_bit] <= 1'b0;
      end
    end
  end

  // Sticky flags: a set in the same cycle beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_status_start <= 1'b0;
      serial_port_irq_flag <= 1'b0;
      write_collision_flag <= 1'b0;
      bus_collision_irq_flag <= 1'b0;
    end else begin
      if (flags_wr && pwdata[irq_flag_bit]) serial_port_irq_flag <= 1'b0;
      if (flags_wr && pwdata[write_collision_flag_bit]) write_collision_flag <= 1'b0;
      if (flags_wr && pwdata[bcol_bit]) bus_collision_irq_flag <= 1'b0;
      if (flags_wr && pwdata[start_seen_bit]) serial_status_start <= 1'b0;
      if (start_det) serial_status_start <= 1'b1;
      if (seq_done_r) serial_port_irq_flag <= 1'b1;
      if (buf_wr && restart_busy) write_collision_flag <= 1'b1;
      if (abort_col || restart_col) bus_collision_irq_flag <= 1'b1;
    end
  end

  // ----------------------------------------
  // Open-drain pins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      // Only ever pull low; the pull-ups make the high level
      sda_out <= 1'b0;
      scl_out <= 1'b0;
      sda_oe <= drive_sda_low;
      scl_oe <= drive_scl_low;
    end
  end
endmodule : i2c_start_seq
`default_nettype wire

// ==== common/i2c_seq_pkg.sv ====
// Constants for the I2C start / repeated-start sequencer.
// Assumes a single pclk domain; register offsets are APB byte addresses.
package i2c_seq_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ctrl_two_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] reload_addr = 12'h008;
  localparam logic [11:0] buffer_addr = 12'h00c;
  localparam logic [11:0] flags_addr = 12'h010;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int start_req_bit = 0;
  localparam int restart_req_bit = 1;
  localparam int low_req_bits = 5;
  localparam int start_seen_bit = 3;
  localparam int irq_flag_bit = 0;
  localparam int write_collision_flag_bit = 1;
  localparam int bcol_bit = 2;
  localparam int busy_bit = 4;
  // ----------------------------------------
  // Reset values and counter step
  // ----------------------------------------
  localparam logic [7:0] ctrl_two_reset = 8'h00;
  localparam logic [6:0] reload_reset = 7'h04;
  localparam logic [7:0] buffer_reset = 8'h00;
  localparam logic [6:0] count_one = 7'h01;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    st_idle,
    st_s_check,
    st_s_count1,
    st_s_count2,
    st_r_scl_low,
    st_r_sda_rel,
    st_r_scl_rise,
    st_r_hold,
    st_r_sda_low
  } seq_state_t;
endpackage : i2c_seq_pkg

// ==== verif/i2c_bus_model.sv ====
// Bus partner: pull-ups on SDA and SCL plus a second master that can hold a line or clock.
// Assumes the design pulls a line low only while its enable is high.
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_model (
  // Design side
  input wire logic sda_oe,
  input wire logic scl_oe,
  // Other master
  input wire logic hold_sda,
  input wire logic hold_scl,
  input wire logic run_clk,
  // Bus levels
  output logic sda,
  output logic scl
);
  logic tick = 1'b0;
  // Its clock stands released outside a burst
  always #80 tick = run_clk ? ~tick : 1'b0;
  // Wired-AND with pull-up: a released line reads high
  assign sda = (sda_oe || hold_sda) ? 1'b0 : 1'b1;
  assign scl = (scl_oe || hold_scl || tick) ? 1'b0 : 1'b1;
endmodule : i2c_bus_model
`default_nettype wire

// ==== verif/i2c_start_seq_sva.sv ====
// Port checker for the start / repeated-start sequencer.
// Assumes zero-wait APB and write-one-to-clear sticky flags.
`timescale 1ns/100ps
`default_nettype none
module i2c_start_seq_chk
  import i2c_seq_pkg::*;
(
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Bus and flags
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic serial_port_irq_flag,
  input wire logic bus_collision_irq_flag
);
  logic clr_irq;
  logic clr_col;
  logic wr_ctl;
  assign wr_ctl = psel && penable && pwrite && paddr == ctrl_two_addr;
  assign clr_irq = psel && penable && pwrite && paddr == flags_addr && pwdata[irq_flag_bit];
  assign clr_col = psel && penable && pwrite && paddr == flags_addr && pwdata[bcol_bit];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_drive_low; sda_out == 1'b0 && scl_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low) else $error("line driven high");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_irq_sda; $rose(serial_port_irq_flag) |-> sda_oe; endproperty
  a_irq_sda: assert property (p_irq_sda) else $error("sda not held at irq");
  // A restart begun with SDA still held also raises scl_oe; its request is two cycles back
  property p_start_irq;
    $rose(scl_oe) && sda_oe && !$past(wr_ctl, 2) |-> ##[0:3] serial_port_irq_flag;
  endproperty
  a_start_irq: assert property (p_start_irq) else $error("no irq after start");
  property p_col_rel; $rose(bus_collision_irq_flag) |-> ##[0:3] (!sda_oe && !scl_oe); endproperty
  a_col_rel: assert property (p_col_rel) else $error("lines kept after collision");
  property p_irq_hold; $fell(serial_port_irq_flag) |-> $past(clr_irq); endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  property p_col_hold; $fell(bus_collision_irq_flag) |-> $past(clr_col); endproperty
  a_col_hold: assert property (p_col_hold) else $error("collision dropped alone");
  c_irq: cover property ($rose(serial_port_irq_flag));
  c_col: cover property ($rose(bus_collision_irq_flag));
  c_err: cover property (pslverr);
endmodule : i2c_start_seq_chk
bind i2c_start_seq i2c_start_seq_chk CHK (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe),
  .serial_port_irq_flag(serial_port_irq_flag), .bus_collision_irq_flag(bus_collision_irq_flag));
`default_nettype wire

// ==== verif/i2c_start_seq_tb_top.sv ====
// Self-checking bench for the start / repeated-start sequencer.
// Assumes the bus partner model; all stimulus moves on rising pclk.
`timescale 1ns/100ps
`default_nettype none
module i2c_start_seq_tb_top
  import i2c_seq_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, rl, s = 32'h00014e56;
  logic pready, pslverr, serr, sda_in, scl_in, sda_out, scl_out, sda_oe, scl_oe;
  logic serial_port_irq_flag, bus_collision_irq_flag;
  logic hold_sda = 1'b0, hold_scl = 1'b0, run_clk = 1'b0;
  int error_cnt = 0, cmp_count = 0, cyc = 0, n;
  int m_reload = 0, m_buf = 0, m_rs = 0;
  i2c_start_seq DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .serial_port_irq_flag(serial_port_irq_flag),
    .bus_collision_irq_flag(bus_collision_irq_flag));
  i2c_bus_model BUS (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda(hold_sda),
    .hold_scl(hold_scl), .run_clk(run_clk), .sda(sda_in), .scl(scl_in));
  always #5 pclk = ~pclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : rnd
  function automatic logic sig(input int k);
    case (k)
      0: return serial_port_irq_flag;
      1: return bus_collision_irq_flag;
      2: return sda_oe;
      default: return scl_oe;
    endcase
  endfunction : sig
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // Idle cycle after each transfer so no request signal is driven twice in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    serr = pslverr;
    // Shadow model: a write lands at this edge, buffer refused during a restart
    if (wr && a == reload_addr) m_reload = int'(d[6:0]);
    if (wr && a == buffer_addr && m_rs == 0) m_buf = int'(d[7:0]);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdchk
  task automatic wt(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      n++;
      @(posedge pclk);
    end
  endtask : wt
  task automatic rst();
    @(posedge pclk);
    presetn <= 1'b0;
    hold_sda <= 1'b0;
    hold_scl <= 1'b0;
    run_clk <= 1'b0;
    m_reload = int'(reload_reset);
    m_buf = int'(buffer_reset);
    m_rs = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst();
    rdchk(reload_addr, 32'(reload_reset), "rl0");
    rdchk(ctrl_two_addr, 32'(ctrl_two_reset), "c0");
    rdchk(status_addr, 32'h0, "st0");
    apb(1'b0, 12'h0fc, 32'h0);
    chk("slverr", 32'h1, serr);
    $display("done regs");
    for (int i = 0; i < 3; i++) begin
      rl = 32'h3 + (rnd() % 32'h8);
      rst();
      apb(1'b1, reload_addr, rl);
      rdchk(reload_addr, m_reload, "rl_mdl");
      apb(1'b1, ctrl_two_addr, 32'h1);
      wt(2, 1'b1, 200);
      chk("sda_dly", 32'h1, n >= rl && n <= rl + 8);
      wt(3, 1'b1, 200);
      chk("scl_dly", 32'h1, n >= rl && n <= rl + 8);
      wt(0, 1'b1, 10);
      rdchk(flags_addr, 32'h1, "flg");
      rdchk(status_addr, 32'h8, "seen");
      apb(1'b1, flags_addr, 32'hf);
      rdchk(flags_addr, 32'h0, "clr");
    end
    $display("done start");
    for (int k = 0; k < 2; k++) begin
      rst();
      hold_sda <= (k == 0);
      hold_scl <= (k == 1);
      repeat (4) @(posedge pclk);
      apb(1'b1, ctrl_two_addr, 32'h1);
      wt(1, 1'b1, 10);
      chk("busy_low", 32'h4, {bus_collision_irq_flag, sda_oe, scl_oe});
      apb(1'b0, status_addr, 32'h0);
      chk("inactive", 32'h0, rd[busy_bit]);
    end
    $display("done abort");
    for (int p = 0; p < 2; p++) begin
      rst();
      apb(1'b1, reload_addr, 32'h14);
      apb(1'b1, ctrl_two_addr, 32'h1);
      if (p == 1)
        wt(2, 1'b1, 100);
      repeat (4) @(posedge pclk);
      run_clk <= 1'b1;
      wt(1, 1'b1, 40);
      chk("col_scl", p == 0, bus_collision_irq_flag);
      run_clk <= 1'b0;
      wt(0, 1'b1, 40);
      chk("irq_scl", p == 1, serial_port_irq_flag);
    end
    rst();
    apb(1'b1, reload_addr, 32'h28);
    apb(1'b1, ctrl_two_addr, 32'h1);
    repeat (6) @(posedge pclk);
    hold_sda <= 1'b1;
    wt(2, 1'b1, 60);
    chk("sda_early", 32'h1, n < 10);
    $display("done collide");
    rst();
    apb(1'b1, reload_addr, 32'h10);
    apb(1'b1, buffer_addr, 32'h5a);
    apb(1'b1, ctrl_two_addr, 32'h2);
    m_rs = 1;
    wt(3, 1'b1, 5);
    chk("scl_first", 32'h2, {scl_oe, sda_oe});
    apb(1'b1, buffer_addr, 32'ha5);
    apb(1'b1, ctrl_two_addr, 32'h1);
    rdchk(ctrl_two_addr, 32'h2, "c_busy");
    rdchk(buffer_addr, m_buf, "buf_keep");
    wt(0, 1'b1, 100);
    m_rs = 0;
    chk("rs_sda", 32'h1, sda_oe);
    rdchk(ctrl_two_addr, 32'h0, "rs_clr");
    rdchk(flags_addr, 32'h3, "rs_flg");
    rdchk(status_addr, 32'h8, "rs_seen");
    apb(1'b1, buffer_addr, 32'ha5);
    rdchk(buffer_addr, m_buf, "buf_load");
    rst();
    apb(1'b1, reload_addr, 32'h10);
    apb(1'b1, ctrl_two_addr, 32'h2);
    wt(3, 1'b1, 5);
    wt(3, 1'b0, 100);
    repeat (4) @(posedge pclk);
    hold_scl <= 1'b1;
    wt(1, 1'b1, 20);
    chk("rs_col", 32'h2, {bus_collision_irq_flag, serial_port_irq_flag});
    $display("done restart");
    end_sim();
  end
endmodule : i2c_start_seq_tb_top
`default_nettype wire
